// File: tsim_delay_line.sv
`timescale 1ns/1ps
// delays a word by a number of position-loop samples
module tsim_delay_line
  import tsim_pkg::*;
#(
  parameter int DEPTH = CCL_EXTRA
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic advance,
  input wire logic [DW-1:0] din,
  output logic [DW-1:0] dout
);
  logic [DEPTH-1:0][DW-1:0] stage_r;
  logic [DEPTH-1:0][DW-1:0] stage_nxt;

  // shift one stage per sample
  always_comb
  begin
    stage_nxt = stage_r;
    if (advance)
    begin
      for (int i = DEPTH - 1; i > 0; i--)
        stage_nxt[i] = stage_r[i-1];
      stage_nxt[0] = din;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stage_r <= '0;
    else
      stage_r <= stage_nxt;
  end

  assign dout = stage_r[DEPTH-1];
endmodule

// File: tsim_far_end.sv
`timescale 1ns/1ps
// ******************************************
// external generator and analyzer model
// ******************************************
module tsim_far_end
  import tsim_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic loop_tick,
  input wire logic [DW-1:0] gen_level,
  input wire logic [DW-1:0] dac_data,
  input wire logic dac_wr,
  output logic [DW-1:0] adc_data,
  output logic [15:0] wr_count,
  output logic [15:0] stray_count,
  output logic [DW-1:0] scope_word
);
  logic tick_d_r;
  // generator level is digitized every cycle; scope logs each dac write
  // stray_count counts writes that do not come one cycle after a tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adc_data <= '0;
      tick_d_r <= 1'b0;
      wr_count <= 16'h0000;
      stray_count <= 16'h0000;
      scope_word <= '0;
    end
    else
    begin
      adc_data <= gen_level;
      tick_d_r <= loop_tick;
      if (dac_wr)
      begin
        wr_count <= wr_count + 16'h0001;
        scope_word <= dac_data;
        if (!tick_d_r)
          stray_count <= stray_count + 16'h0001; // write outside a sample
      end
    end
  end
endmodule

// File: tsim_monitor.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module tsim_monitor
  import tsim_pkg::*;
#(
  parameter bit CCL_SUPPORT = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic loop_tick,
  input wire logic [DW-1:0] adc_data,
  input wire logic [DW-1:0] ctrl_out,
  input wire logic [DW-1:0] position,
  input wire logic [DW-1:0] pos_error,
  input wire logic [DW-1:0] setpoint_pos,
  input wire logic [CCL_COUNT-1:0][DW-1:0] ccl_signals,
  output logic [DW-1:0] u1_inject,
  output logic [DW-1:0] u2_inject,
  output logic [DW-1:0] dac_data,
  output logic dac_wr,
  output logic conflict_err
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // clip a wide signed value into the data width
  function automatic logic [DW-1:0] sat_dw(input logic signed [DW:0] v);
    logic signed [DW:0] hi;
    hi = {1'b0, INJ_LIMIT};
    if (v > hi)
      sat_dw = INJ_LIMIT;
    else if (v < -hi)
      sat_dw = -INJ_LIMIT;
    else
      sat_dw = v[DW-1:0];
  endfunction

  function automatic logic is_ccl(input logic [4:0] sel);
    is_ccl = (sel >= MON_Y6) && (sel <= MON_Y18);
  endfunction

  // ****************************************************************
  // settings and register bus
  // ****************************************************************
  logic [1:0] inj_sel_r, inj_sel_nxt;
  logic [4:0] mon_sel_r, mon_sel_nxt;
  logic aaf_en_r, aaf_en_nxt;
  logic rate32_r, rate32_nxt;
  logic [DW-1:0] in_gain_r, in_gain_nxt;
  logic [DW-1:0] out_gain_r, out_gain_nxt;
  logic err_r, err_nxt;
  logic rej_r, rej_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic t;
  logic conflict;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic [4:0] wmon;

  // loop state, declared here for readback
  logic [1:0] inj_act_r, inj_act_nxt;
  logic [4:0] mon_act_r, mon_act_nxt;
  logic [DW-1:0] offset_r, offset_nxt;
  logic [DW-1:0] u1_r, u1_nxt;
  logic [DW-1:0] u2_r, u2_nxt;
  logic [DW-1:0] dac_r, dac_nxt;
  logic dac_wr_r, dac_wr_nxt;
  logic conflict_r, conflict_nxt;

  assign t = loop_tick & ce;
  assign setup = ce & psel & ~penable & ~pready_r;
  assign access = ce & psel & penable & pready_r;
  assign wr = access & pwrite;
  assign wmon = pwdata[CTRL_MON_LSB +: 5];
  // 32 kHz rate forbids anti-alias with monitor or injection
  assign conflict = rate32_r & aaf_en_r & ((mon_sel_r != MON_NONE) | (inj_sel_r != INJ_NONE));

  // address decode, readback, writes and sticky flags
  always_comb
  begin
    inj_sel_nxt = inj_sel_r;
    mon_sel_nxt = mon_sel_r;
    aaf_en_nxt = aaf_en_r;
    rate32_nxt = rate32_r;
    in_gain_nxt = in_gain_r;
    out_gain_nxt = out_gain_r;
    err_nxt = err_r;
    rej_nxt = rej_r;
    pready_nxt = pready_r;
    pslverr_nxt = pslverr_r;
    prdata_nxt = prdata_r;
    mapped = 1'b1;
    if (paddr == ADDR_CTRL)
      prdata_nxt = {18'h00000, rate32_r, aaf_en_r, 3'h0, mon_sel_r, 2'h0, inj_sel_r};
    else if (paddr == ADDR_IN_GAIN)
      prdata_nxt = {16'h0000, in_gain_r};
    else if (paddr == ADDR_OUT_GAIN)
      prdata_nxt = {16'h0000, out_gain_r};
    else if (paddr == ADDR_STATUS)
      prdata_nxt = {19'h00000, mon_act_r, 2'h0, inj_act_r, 2'h0, rej_r, err_r};
    else if (paddr == ADDR_DAC)
      prdata_nxt = {16'h0000, dac_r};
    else if (paddr == ADDR_OFFSET)
      prdata_nxt = {16'h0000, offset_r};
    else
    begin
      mapped = 1'b0;
      prdata_nxt = 32'h00000000;
    end
    if (setup)
    begin
      pready_nxt = 1'b1;
      pslverr_nxt = ~mapped;
      if (pwrite)
        prdata_nxt = 32'h00000000;
    end
    else if (access)
    begin
      pready_nxt = 1'b0;
      pslverr_nxt = 1'b0;
    end
    if (wr && mapped && paddr == ADDR_CTRL)
    begin
      inj_sel_nxt = pwdata[CTRL_INJ_LSB +: 2];
      aaf_en_nxt = pwdata[CTRL_AAF_BIT];
      rate32_nxt = pwdata[CTRL_RATE32_BIT];
      // R13: variant gate
      if (is_ccl(wmon) && !CCL_SUPPORT)
        rej_nxt = 1'b1;
      else if (wmon <= MON_Y18)
        mon_sel_nxt = wmon;
      else
        rej_nxt = 1'b1;
    end
    if (wr && mapped && paddr == ADDR_IN_GAIN)
      in_gain_nxt = pwdata[DW-1:0];
    if (wr && mapped && paddr == ADDR_OUT_GAIN)
      out_gain_nxt = pwdata[DW-1:0];
    if (wr && mapped && paddr == ADDR_STATUS)
    begin
      if (pwdata[ST_ERR_BIT])
        err_nxt = 1'b0;
      if (pwdata[ST_REJ_BIT])
        rej_nxt = 1'b0;
    end
    // R25: conflict error, set wins over clear
    if (t && conflict)
      err_nxt = 1'b1;
    if (wr && mapped && paddr == ADDR_CTRL && (is_ccl(wmon) && !CCL_SUPPORT || wmon > MON_Y18))
      rej_nxt = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inj_sel_r <= INJ_NONE;
      mon_sel_r <= MON_NONE;
      aaf_en_r <= 1'b0;
      rate32_r <= 1'b0;
      in_gain_r <= GAIN_UNITY;
      out_gain_r <= GAIN_UNITY;
      err_r <= 1'b0;
      rej_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end
    else if (ce)
    begin
      inj_sel_r <= inj_sel_nxt;
      mon_sel_r <= mon_sel_nxt;
      aaf_en_r <= aaf_en_nxt;
      rate32_r <= rate32_nxt;
      in_gain_r <= in_gain_nxt;
      out_gain_r <= out_gain_nxt;
      err_r <= err_nxt;
      rej_r <= rej_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ****************************************************************
  // scaling and current-loop delay
  // ****************************************************************
  tsim_scale_if #(.W(DW)) in_if ();
  tsim_scale_if #(.W(DW)) out_if ();
  logic [DW-1:0] ccl_raw;
  logic [DW-1:0] ccl_del;
  logic [DW-1:0] angle_scaled;
  logic [2*DW-1:0] angle_prod;
  logic [DW-1:0] mon_raw;

  // R4 R5: input gain before injection
  assign in_if.sample = adc_data;
  assign in_if.gain = in_gain_r;
  tsim_scaler #(.LIMIT(INJ_LIMIT)) u_in_scale (.s(in_if));

  // R18: angle pre-scaled to 3.14 V per radian
  assign angle_prod = $signed(ccl_signals[CCL_COUNT-1]) * $signed(ANGLE_GAIN);
  assign angle_scaled = sat_dw(angle_prod[DW+GAIN_FRAC:GAIN_FRAC]);
  // R14 R15 R16 R17: current-loop signal by index
  assign ccl_raw = (mon_sel_r == MON_Y18) ? angle_scaled :
                   is_ccl(mon_sel_r) ? ccl_signals[mon_sel_r - MON_Y6] : '0;

  // R22: two extra samples of delay for current-loop signals
  tsim_delay_line #(.DEPTH(CCL_EXTRA)) u_ccl_delay (
    .pclk(pclk),
    .presetn(presetn),
    .advance(t),
    .din(ccl_raw),
    .dout(ccl_del)
  );

  // R11: output gain then R24 clip at ten volts
  assign out_if.sample = mon_raw;
  assign out_if.gain = out_gain_r;
  tsim_scaler #(.LIMIT(DAC_LIMIT)) u_out_scale (.s(out_if));

  // ****************************************************************
  // position-loop sample
  // ****************************************************************
  // R20 R21: monitor source mux, same-sample path
  always_comb
  begin
    offset_nxt = offset_r;
    mon_raw = '0;
    // R9: capture offset when position output becomes active
    if (t && mon_sel_r == MON_Y3 && mon_act_r != MON_Y3)
      offset_nxt = position;
    case (mon_sel_r)
      // R7: controller output only
      MON_Y1: mon_raw = ctrl_out;
      // R8: controller output plus U2
      MON_Y2: mon_raw = sat_dw($signed({ctrl_out[DW-1], ctrl_out}) + $signed({u2_r[DW-1], u2_r}));
      // R9: position minus captured offset
      MON_Y3: mon_raw = sat_dw($signed({position[DW-1], position})
        - $signed({offset_nxt[DW-1], offset_nxt}));
      // R10: position error
      MON_Y4: mon_raw = pos_error;
      // R12: setpoint position
      MON_Y5: mon_raw = setpoint_pos;
      default: mon_raw = ccl_del;
    endcase
  end

  // R26: settings take effect at the sample, R23 one update per sample
  always_comb
  begin
    inj_act_nxt = inj_act_r;
    mon_act_nxt = mon_act_r;
    u1_nxt = u1_r;
    u2_nxt = u2_r;
    dac_nxt = dac_r;
    dac_wr_nxt = 1'b0;
    conflict_nxt = conflict_r;
    if (t)
    begin
      inj_act_nxt = inj_sel_r;
      mon_act_nxt = mon_sel_r;
      conflict_nxt = conflict;
      // R1: no injection unless selected
      u1_nxt = '0;
      u2_nxt = '0;
      // R2: U1 injection, R3: U2 injection
      if (!conflict && inj_sel_r == INJ_POS)
        u1_nxt = in_if.result;
      else if (!conflict && inj_sel_r == INJ_CTRL)
        u2_nxt = in_if.result;
      // R6: no DAC write when none; R19: only at the sample
      if (!conflict && mon_sel_r != MON_NONE)
      begin
        dac_nxt = out_if.result;
        dac_wr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      inj_act_r <= INJ_NONE;
      mon_act_r <= MON_NONE;
      offset_r <= '0;
      u1_r <= '0;
      u2_r <= '0;
      dac_r <= '0;
      dac_wr_r <= 1'b0;
      conflict_r <= 1'b0;
    end
    else if (ce)
    begin
      inj_act_r <= inj_act_nxt;
      mon_act_r <= mon_act_nxt;
      offset_r <= offset_nxt;
      u1_r <= u1_nxt;
      u2_r <= u2_nxt;
      dac_r <= dac_nxt;
      dac_wr_r <= dac_wr_nxt;
      conflict_r <= conflict_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign u1_inject = u1_r;
  assign u2_inject = u2_r;
  assign dac_data = dac_r;
  assign dac_wr = dac_wr_r;
  assign conflict_err = conflict_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_NO_INJECT: assert property (t && inj_sel_r == INJ_NONE |=> u1_r == '0 && u2_r == '0) // R1
    else $error("injection seen while selector is none");
  AST_U1_INJECT: assert property (t && inj_sel_r == INJ_POS && !conflict
    |=> u1_r == $past(in_if.result) && u2_r == '0) // R2
    else $error("U1 does not carry scaled input");
  AST_U2_INJECT: assert property (t && inj_sel_r == INJ_CTRL && !conflict
    |=> u2_r == $past(in_if.result) && u1_r == '0) // R3
    else $error("U2 does not carry scaled input");
  AST_NO_DAC_WRITE: assert property (t && mon_sel_r == MON_NONE |=> !dac_wr_r) // R6
    else $error("DAC written while monitor is none");
  AST_DAC_ON_SAMPLE: assert property (dac_wr_r && $past(ce) // R19
    |-> $past(t) && $past(mon_sel_r) != MON_NONE)
    else $error("DAC written outside a loop sample");
  AST_DAC_RANGE: assert property ($signed(dac_r) <= $signed(DAC_LIMIT)
    && $signed(dac_r) >= -$signed(DAC_LIMIT)) // R24
    else $error("DAC value beyond ten volts");
  AST_Y1_UNITY: assert property (t && mon_sel_r == MON_Y1 && !conflict && out_gain_r == GAIN_UNITY
    && $signed(ctrl_out) <= $signed(DAC_LIMIT) && $signed(ctrl_out) >= -$signed(DAC_LIMIT)
    |=> dac_wr_r && dac_r == $past(ctrl_out)) // R7
    else $error("Y1 not passed at unity gain");
  AST_CONFLICT_ERR: assert property (t && conflict |=> err_r && conflict_r ##1 err_r) // R25
    else $error("anti-alias conflict not flagged");
  AST_CCL_GATE: assert property (mon_sel_r <= MON_Y18 && (CCL_SUPPORT || !is_ccl(mon_sel_r))) // R13
    else $error("current-loop selection accepted on unsupported variant");
  AST_Y3_ZERO: assert property (t && mon_sel_r == MON_Y3 && mon_act_r != MON_Y3 && !conflict
    |=> dac_r == '0) // R9
    else $error("position output not zero at capture");

  COV_U1: cover property (t && inj_sel_r == INJ_POS && !conflict);
  COV_Y3: cover property (t && mon_sel_r == MON_Y3 && mon_act_r != MON_Y3);
  COV_CCL: cover property (t && is_ccl(mon_sel_r) ##1 dac_wr_r);
  COV_CONFLICT: cover property (t && conflict);
  COV_CLIP: cover property (t && out_if.sat);
endmodule

// File: tsim_monitor_tb.sv
`timescale 1ns/1ps
module tsim_monitor_tb
  import tsim_pkg::*;
();
  logic pclk, presetn, ce, psel, penable, pwrite, loop_tick, pready, pslverr, rerr;
  logic dac_wr, conflict_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DW-1:0] gen_level, adc_data, ctrl_out, position, pos_error, setpoint_pos;
  logic [DW-1:0] u1_inject, u2_inject, dac_data, scope_word;
  logic [CCL_COUNT-1:0][DW-1:0] ccl_signals;
  logic [15:0] wr_count, stray_count, wr_snap;
  int failures, compares, i, e;
  // ******************************************
  // instances
  // ******************************************
  tsim_monitor u_tsim_monitor (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loop_tick(loop_tick), .adc_data(adc_data),
    .ctrl_out(ctrl_out), .position(position), .pos_error(pos_error),
    .setpoint_pos(setpoint_pos), .ccl_signals(ccl_signals), .u1_inject(u1_inject),
    .u2_inject(u2_inject), .dac_data(dac_data), .dac_wr(dac_wr),
    .conflict_err(conflict_err));
  tsim_far_end u_tsim_far_end (.pclk(pclk), .presetn(presetn), .loop_tick(loop_tick),
    .gen_level(gen_level), .dac_data(dac_data), .dac_wr(dac_wr), .adc_data(adc_data),
    .wr_count(wr_count), .stray_count(stray_count), .scope_word(scope_word));
  // 200 MHz clock
  always #2.5 pclk = ~pclk;
  // ******************************************
  // tasks
  // ******************************************
  task conclude();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, x, g);
    end
  endtask
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      chk("apb_wait", 32'h1, 32'h0);
      conclude();
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input string s, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(s, x, rd);
  endtask
  task cfg(input logic [1:0] inj, input logic [4:0] mon, input logic [1:0] fl);
    apb(1'b1, ADDR_CTRL, {18'h0, fl, 3'h0, mon, 2'h0, inj});
  endtask
  // one sample tick, outputs settled on return
  task tick();
    @(posedge pclk);
    loop_tick <= 1'b1;
    @(posedge pclk);
    loop_tick <= 1'b0;
    #1;
  endtask
  // ******************************************
  // main sequence
  // ******************************************
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    loop_tick = 1'b0;
    gen_level = 16'h03e8;
    ctrl_out = 16'h05dc;
    position = 16'h0000;
    pos_error = 16'h0111;
    setpoint_pos = 16'h0222;
    ccl_signals = '0;
    failures = 0;
    compares = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl", ADDR_CTRL, 32'h0);
    rdchk("in_gain", ADDR_IN_GAIN, 32'h100);
    rdchk("out_gain", ADDR_OUT_GAIN, 32'h100);
    apb(1'b0, 12'h018, 32'h0);
    chk("unmapped", 32'h1, 32'(rerr));
    $display("test reset done");
    tick();
    tick();
    chk("u1_none", 32'h0, 32'(u1_inject));
    chk("u2_none", 32'h0, 32'(u2_inject));
    chk("writes_none", 32'h0, 32'(wr_count));
    cfg(INJ_POS, MON_NONE, 2'h0);
    tick();
    chk("u1_pos", 32'h3e8, 32'(u1_inject));
    chk("u2_pos", 32'h0, 32'(u2_inject));
    apb(1'b1, ADDR_IN_GAIN, 32'h200);
    chk("u1_hold", 32'h3e8, 32'(u1_inject));
    tick();
    chk("u1_gain", 32'h7d0, 32'(u1_inject));
    cfg(INJ_CTRL, MON_NONE, 2'h0);
    tick();
    chk("u2_ctrl", 32'h7d0, 32'(u2_inject));
    chk("u1_ctrl", 32'h0, 32'(u1_inject));
    $display("test inject done");
    cfg(INJ_CTRL, MON_Y1, 2'h0);
    tick();
    chk("dac_y1", 32'h5dc, 32'(dac_data));
    chk("dac_wr", 32'h1, 32'(dac_wr));
    cfg(INJ_CTRL, MON_Y2, 2'h0);
    tick();
    chk("dac_y2", 32'hdac, 32'(dac_data));
    @(posedge pclk);
    ctrl_out <= 16'h2328;
    tick();
    chk("dac_sat_hi", 32'h2710, 32'(dac_data));
    cfg(INJ_NONE, MON_Y1, 2'h0);
    apb(1'b1, ADDR_OUT_GAIN, 32'h80);
    ctrl_out <= 16'h0bb8;
    tick();
    chk("dac_gain", 32'h5dc, 32'(dac_data));
    apb(1'b1, ADDR_OUT_GAIN, 32'h100);
    ctrl_out <= 16'hb1e0;
    tick();
    chk("dac_sat_lo", 32'hd8f0, 32'(dac_data));
    for (i = 0; i < 2; i++)
    begin
      cfg(INJ_NONE, 5'(MON_Y4 + i), 2'h0);
      tick();
      chk("dac_pos", (i == 0) ? 32'h111 : 32'h222, 32'(dac_data));
    end
    @(posedge pclk);
    position <= 16'h0bb8;
    cfg(INJ_NONE, MON_Y3, 2'h0);
    tick();
    chk("dac_y3_first", 32'h0, 32'(dac_data));
    @(posedge pclk);
    position <= 16'h0dac;
    tick();
    chk("dac_y3", 32'h1f4, 32'(dac_data));
    $display("test position loop done");
    @(posedge pclk);
    for (i = 0; i < CCL_COUNT; i++)
      ccl_signals[i] <= 16'(100 * (i + 1));
    for (i = 0; i < CCL_COUNT; i++)
    begin
      cfg(INJ_NONE, 5'(MON_Y6 + i), 2'h0);
      repeat (3) tick();
      e = (i == 12) ? 1300 * 32'(ANGLE_GAIN) / 256 : 100 * (i + 1);
      chk("dac_ccl", 32'(e), 32'(dac_data));
    end
    cfg(INJ_NONE, MON_Y6, 2'h0);
    repeat (3) tick();
    @(posedge pclk);
    ccl_signals[0] <= 16'h00c8;
    tick();
    chk("ccl_lat1", 32'h64, 32'(dac_data));
    tick();
    chk("ccl_lat2", 32'h64, 32'(dac_data));
    tick();
    chk("ccl_lat3", 32'hc8, 32'(dac_data));
    $display("test current loop done");
    cfg(INJ_POS, MON_Y1, 2'h3);
    tick();
    wr_snap = wr_count;
    tick();
    chk("conflict", 32'h1, 32'(conflict_err));
    chk("u1_blocked", 32'h0, 32'(u1_inject));
    chk("no_write", 32'(wr_snap), 32'(wr_count));
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("err_flag", 32'h1, 32'(rd[ST_ERR_BIT]));
    cfg(INJ_POS, MON_Y1, 2'h1);
    tick();
    chk("conflict_off", 32'h0, 32'(conflict_err));
    chk("dac_wr_16k", 32'h1, 32'(dac_wr));
    cfg(INJ_NONE, 5'h13, 2'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("rej_flag", 32'h1, 32'(rd[ST_REJ_BIT]));
    chk("mon_kept", 32'h1, 32'(rd[ST_MON_LSB +: 5]));
    rdchk("mon_sel_kept", ADDR_CTRL, 32'h10);
    apb(1'b1, ADDR_STATUS, 32'h3);
    rdchk("status_clr", ADDR_STATUS, 32'h110);
    @(posedge pclk);
    ce <= 1'b0;
    wr_snap = wr_count;
    tick();
    chk("ce_frozen", 32'(wr_snap), 32'(wr_count));
    @(posedge pclk);
    ce <= 1'b1;
    chk("scope", 32'hd8f0, 32'(scope_word));
    chk("stray", 32'h0, 32'(stray_count));
    $display("test conflict done");
    conclude();
  end
endmodule

// File: tsim_pkg.sv
// What this block does
// R1: selector none injects no test signal
// R2: position setting injects scaled input at U1
// R3: controller setting injects scaled input at U2
// R4: input scaled by input gain, 1 V = 1 pu
// R5: at U2 unity gain 1 V = 1 A
// R6: monitor none means no DAC writes
// R7: controller setting outputs Y1 without test signal
// R8: plus-test setting outputs Y1 plus U2 (Y2)
// R9: position setting captures offset, outputs Y3 minus offset
// R10: position error setting outputs Y4
// R11: output scaled by gain, Y1/Y2 1 A = 1 V
// R12: Y3, Y4, Y5 output at 1 V per pu
// R13: Y6..Y18 accepted only on supporting variants
// R14: Y6..Y11 currents before/after park and errors
// R15: Y12..Y18 integrators, voltages and electrical angle
// R16: currents and errors at 1 V per ampere
// R17: integrators and voltages at 1 V per volt
// R18: angle output at 3.14 V per radian
// R19: DAC updated only by position-loop sample
// R20: POSITION_VELOCITY_LOOP paths take one loop period
// R21: U2 to Y1 at most two periods
// R22: current-loop signals take three periods
// R23: one input sample and output update per period
// R24: output clipped at plus/minus ten volts
// R25: anti-alias plus monitor at 32 kHz raises error
// R26: settings per axis, applied at next sample
package tsim_pkg;
  // data scale: one count is one milli unit (mV, mA, mpu, mrad)
  localparam int DW = 16;
  localparam int GAIN_FRAC = 8;
  localparam logic [15:0] GAIN_UNITY = 16'h0100;
  localparam logic [15:0] DAC_LIMIT = 16'h2710;
  localparam logic [15:0] INJ_LIMIT = 16'h7fff;
  localparam logic [15:0] ANGLE_GAIN = 16'h0324;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_IN_GAIN = 12'h004;
  localparam logic [11:0] ADDR_OUT_GAIN = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00c;
  localparam logic [11:0] ADDR_DAC = 12'h010;
  localparam logic [11:0] ADDR_OFFSET = 12'h014;
  // control fields
  localparam int CTRL_INJ_LSB = 0;
  localparam int CTRL_MON_LSB = 4;
  localparam int CTRL_AAF_BIT = 12;
  localparam int CTRL_RATE32_BIT = 13;
  // status fields
  localparam int ST_ERR_BIT = 0;
  localparam int ST_REJ_BIT = 1;
  localparam int ST_INJ_LSB = 4;
  localparam int ST_MON_LSB = 8;
  // injection point codes
  localparam logic [1:0] INJ_NONE = 2'h0;
  localparam logic [1:0] INJ_POS = 2'h1;
  localparam logic [1:0] INJ_CTRL = 2'h2;
  // monitor selection codes
  localparam logic [4:0] MON_NONE = 5'h00;
  localparam logic [4:0] MON_Y1 = 5'h01;
  localparam logic [4:0] MON_Y2 = 5'h02;
  localparam logic [4:0] MON_Y3 = 5'h03;
  localparam logic [4:0] MON_Y4 = 5'h04;
  localparam logic [4:0] MON_Y5 = 5'h05;
  localparam logic [4:0] MON_Y6 = 5'h06;
  localparam logic [4:0] MON_Y18 = 5'h12;
  localparam int CCL_COUNT = 13;
  // latencies in position-loop periods
  localparam int PVL_PERIODS = 1;
  localparam int CCL_PERIODS = 3;
  localparam int CCL_EXTRA = CCL_PERIODS - PVL_PERIODS;
endpackage

// File: tsim_scale_if.sv
`timescale 1ns/1ps
// sample and gain to a scaler, clipped result back
interface tsim_scale_if #(parameter int W = 16);
  logic signed [W-1:0] sample;
  logic signed [W-1:0] gain;
  logic signed [W-1:0] result;
  logic sat;
  modport client (output sample, output gain, input result, input sat);
  modport server (input sample, input gain, output result, output sat);
endinterface

// File: tsim_scaler.sv
`timescale 1ns/1ps
// signed Q8.8 gain multiply with symmetric clipping
module tsim_scaler
  import tsim_pkg::*;
#(
  parameter logic [15:0] LIMIT = DAC_LIMIT
)
(
  tsim_scale_if.server s
);
  logic signed [2*DW-1:0] prod;
  logic signed [2*DW-1:0] shifted;
  logic signed [2*DW-1:0] lim;

  // multiply, drop fraction, clip
  always_comb
  begin
    prod = s.sample * s.gain;
    shifted = prod >>> GAIN_FRAC;
    lim = {{DW{1'b0}}, LIMIT};
    s.sat = 1'b0;
    s.result = shifted[DW-1:0];
    if (shifted > lim)
    begin
      s.result = LIMIT;
      s.sat = 1'b1;
    end
    else if (shifted < -lim)
    begin
      s.result = -LIMIT;
      s.sat = 1'b1;
    end
  end
endmodule
